// >>> rtl/hsq_top.v
// homing sequencer with apb registers and motion task starter
//
// Contract
// - mode 12 starts moving in homing direction
// - switch active in direction: load, ramp down
// - mechanical stop when following error exceeds threshold
// - current command clamped to homing peak current
// - stop before switch: reverse until switch crossed
// - after crossing: ramp to zero, reverse again
// - switch again in direction: load, ramp down
// - switch active at start: reverse reset move
// - switch inactive: ramp zero, restart homing
// - mode 13 adopts multi-turn feedback position
// - mode 13 sets homed flag
// - feedback offset stored and saved nonvolatile
// - tasks start by input, bcd, network, chaining
// - only loaded task entries affect motion
// - mode 10: reverse to index, second stop fails
`timescale 1ns/1ps
`include "hsq_regs.vh"
module hsq_top
(
    // clock and reset
    input  wire               pclk,
    input  wire               presetn,
    // apb slave
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire        [7:0]  paddr,
    input  wire        [31:0] pwdata,
    output reg         [31:0] prdata,
    output reg                pready,
    output reg                pslverr,
    // pins from the machine
    input  wire               home_switch,
    input  wire               index_pulse,
    input  wire               task_input,
    input  wire        [3:0]  bcd_inputs,
    input  wire               bcd_strobe,
    // position loop, same clock
    input  wire               drive_enable,
    input  wire signed [31:0] following_error,
    input  wire        [31:0] loop_feedback_position,
    input  wire signed [15:0] current_demand,
    input  wire               task_done,
    input  wire        [31:0] nv_offset,
    // motion outputs
    output reg  signed [15:0] vel_cmd,
    output reg  signed [15:0] current_cmd,
    output reg                pos_load,
    output reg         [31:0] pos_load_value,
    output reg                nv_save,
    output reg         [31:0] nv_save_value,
    output wire               task_start,
    output wire        [3:0]  task_index,
    output wire        [31:0] task_target
);
    // one-hot sequencer states
    localparam [8:0] ST_IDLE  = 9'h001;
    localparam [8:0] ST_RSTMV = 9'h002;
    localparam [8:0] ST_RSTSP = 9'h004;
    localparam [8:0] ST_SEEK  = 9'h008;
    localparam [8:0] ST_REV   = 9'h010;
    localparam [8:0] ST_REVSP = 9'h020;
    localparam [8:0] ST_IDX   = 9'h040;
    localparam [8:0] ST_SETL  = 9'h080;
    localparam [8:0] ST_HALT  = 9'h100;

    // software registers
    reg        [3:0]  mode;
    reg               dir_pos;
    reg               auto_home_on_enable;
    reg        [31:0] home_pos;
    reg        [31:0] stop_error_threshold;
    reg        [15:0] homing_peak_current;
    reg        [15:0] home_vel;
    reg        [15:0] accel_step;
    reg        [31:0] feedback_position_offset;
    reg        [3:0]  stg_index;
    reg        [3:0]  stg_next;
    reg               stg_chain;
    reg        [31:0] stg_target;
    reg        [5:0]  tcfg;
    reg               net_start;
    reg        [3:0]  net_index;
    reg               task_load;
    reg               start_req;
    reg               save_req;
    // sequencer state
    reg        [8:0]  state;
    reg        [8:0]  next_state;
    reg               done;
    reg               err;
    reg               homed;
    reg               stop_seen;
    reg               crossed;
    reg               err_after_rev_ok; // stop masked after a reversal
    reg               nv_loaded;
    reg               en_q;
    reg signed [15:0] target;
    // synchronisers: home, index, task input, bcd strobe, bcd
    reg        [7:0]  sync1;
    reg        [7:0]  sync2;
    reg        [3:0]  edge_q;
    wire signed [15:0] ramp_vel;
    wire              ramp_zero;

    wire wr_en  = psel & penable & pready & pwrite;
    wire sw_on  = sync2[0];
    wire sw_rise = sync2[0] & ~edge_q[0];
    wire sw_fall = ~sync2[0] & edge_q[0];
    wire idx_rise = sync2[1] & ~edge_q[1];
    wire din_rise = sync2[2] & ~edge_q[2];
    wire bcd_rise = sync2[3] & ~edge_q[3];
    wire busy = ~state[0];
    wire signed [15:0] hv = $signed(home_vel);
    wire moving_dir = dir_pos ? (ramp_vel > 16'sh0000)
                              : (ramp_vel < 16'sh0000);
    wire [31:0] err_mag = following_error[31] ? (~following_error + 32'h1)
                                              : following_error;
    wire mech_stop = busy & (err_mag > stop_error_threshold);
    wire go = start_req | (auto_home_on_enable & drive_enable & ~en_q);

    // two flops on each pin before any use; edge memory after that
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1  <= 8'h00;
            sync2  <= 8'h00;
            edge_q <= 4'h0;
            en_q   <= 1'b0;
        end
        else
        begin
            sync1  <= {bcd_inputs, bcd_strobe, task_input, index_pulse,
                       home_switch};
            sync2  <= sync1;
            edge_q <= sync2[3:0];
            en_q   <= drive_enable;
        end
    end

    // apb register writes and one-cycle command pulses
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode                 <= `HSQ_MODE_RST;
            dir_pos              <= 1'b1;
            auto_home_on_enable  <= 1'b0;
            home_pos             <= 32'h00000000;
            stop_error_threshold <= `HSQ_THRESH_RST;
            homing_peak_current  <= `HSQ_IPEAK_RST;
            home_vel             <= `HSQ_HVEL_RST;
            accel_step           <= `HSQ_ACCEL_RST;
            feedback_position_offset <= 32'h00000000;
            stg_index  <= 4'h0;
            stg_next   <= 4'h0;
            stg_chain  <= 1'b0;
            stg_target <= 32'h00000000;
            tcfg       <= 6'h00;
            net_start  <= 1'b0;
            net_index  <= 4'h0;
            task_load  <= 1'b0;
            start_req  <= 1'b0;
            save_req   <= 1'b0;
            nv_loaded  <= 1'b0;
        end
        else
        begin
            net_start <= 1'b0;
            task_load <= 1'b0;
            start_req <= 1'b0;
            save_req  <= 1'b0;
            // restore the saved offset once after reset release
            nv_loaded <= 1'b1;
            if (!nv_loaded)
                feedback_position_offset <= nv_offset;
            if (wr_en)
            begin
                case (paddr)
                    `HSQ_CTRL_OFF:
                    begin
                        start_req <= pwdata[`HSQ_CTRL_START];
                        dir_pos   <= pwdata[`HSQ_CTRL_DIR];
                        auto_home_on_enable <= pwdata[`HSQ_CTRL_AUTO];
                        save_req  <= pwdata[`HSQ_CTRL_SAVE];
                        mode <= pwdata[`HSQ_CTRL_MODE_HI:`HSQ_CTRL_MODE_LO];
                    end
                    `HSQ_HOMEPOS_OFF: home_pos <= pwdata;
                    `HSQ_THRESH_OFF:  stop_error_threshold <= pwdata;
                    `HSQ_IPEAK_OFF:   homing_peak_current <= pwdata[15:0];
                    `HSQ_HVEL_OFF:    home_vel <= pwdata[15:0];
                    `HSQ_ACCEL_OFF:   accel_step <= pwdata[15:0];
                    `HSQ_FBOFS_OFF:   feedback_position_offset <= pwdata;
                    `HSQ_TSTAGE_OFF:
                    begin
                        stg_index <= pwdata[3:0];
                        stg_next  <= pwdata[`HSQ_TST_NEXT_HI:`HSQ_TST_NEXT_LO];
                        stg_chain <= pwdata[`HSQ_TST_CHAIN];
                    end
                    `HSQ_TTARGET_OFF: stg_target <= pwdata;
                    `HSQ_TLOAD_OFF:   task_load <= pwdata[0];
                    `HSQ_TCMD_OFF:
                    begin
                        net_start <= 1'b1;
                        net_index <= pwdata[3:0];
                    end
                    `HSQ_TCFG_OFF:    tcfg <= pwdata[5:0];
                    default:          ;
                endcase
            end
        end
    end

    // apb read mux, ready and error decided in the setup cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable)
            begin
                prdata <= 32'h00000000;
                case (paddr)
                    `HSQ_CTRL_OFF:    prdata <= {24'h0, mode, 1'b0,
                                         auto_home_on_enable, dir_pos, 1'b0};
                    `HSQ_STATUS_OFF:  prdata <= {19'h0, state, stop_seen,
                                                 homed, err, done};
                    `HSQ_HOMEPOS_OFF: prdata <= home_pos;
                    `HSQ_THRESH_OFF:  prdata <= stop_error_threshold;
                    `HSQ_IPEAK_OFF:   prdata <= {16'h0, homing_peak_current};
                    `HSQ_HVEL_OFF:    prdata <= {16'h0, home_vel};
                    `HSQ_ACCEL_OFF:   prdata <= {16'h0, accel_step};
                    `HSQ_FBOFS_OFF:   prdata <= feedback_position_offset;
                    `HSQ_TSTAGE_OFF:  prdata <= {23'h0, stg_chain, stg_next,
                                                 stg_index};
                    `HSQ_TTARGET_OFF: prdata <= stg_target;
                    `HSQ_TLOAD_OFF:   ;
                    `HSQ_TCMD_OFF:    prdata <= {27'h0, task_start,
                                                 task_index};
                    `HSQ_TCFG_OFF:    prdata <= {26'h0, tcfg};
                    default:          pslverr <= 1'b1;
                endcase
            end
        end
    end

    // sequencer next state and speed target
    always @*
    begin
        next_state = state;
        target     = 16'sh0000;
        case (state)
            ST_IDLE:
            begin
                if (go && mode == `HSQ_MODE_SWITCH)
                    next_state = sw_on ? ST_RSTMV : ST_SEEK;
                else if (go && mode == `HSQ_MODE_INDEX)
                    next_state = ST_SEEK;
            end
            ST_RSTMV:
            begin
                target = dir_pos ? -hv : hv;
                if (!sw_on)
                    next_state = ST_RSTSP;
            end
            ST_RSTSP:
                if (ramp_zero)
                    next_state = ST_SEEK;
            ST_SEEK:
            begin
                target = dir_pos ? hv : -hv;
                if (mode == `HSQ_MODE_SWITCH && sw_rise && moving_dir)
                    next_state = ST_SETL;
                else if (mech_stop && stop_seen)
                    next_state = ST_HALT;
                else if (mech_stop)
                    next_state = (mode == `HSQ_MODE_INDEX) ? ST_IDX
                                                           : ST_REV;
            end
            ST_REV:
            begin
                target = dir_pos ? -hv : hv;
                if (crossed && sw_fall)
                    next_state = ST_REVSP;
                else if (mech_stop && !err_after_rev_ok)
                    next_state = ST_HALT;
            end
            ST_REVSP:
                if (ramp_zero)
                    next_state = ST_SEEK;
            ST_IDX:
            begin
                target = dir_pos ? -hv : hv;
                if (idx_rise)
                    next_state = ST_SETL;
                else if (mech_stop && !err_after_rev_ok)
                    next_state = ST_HALT;
            end
            ST_SETL:
                if (ramp_zero)
                    next_state = ST_IDLE;
            ST_HALT:
                if (ramp_zero)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // state register, flags and position load
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state     <= ST_IDLE;
            done      <= 1'b0;
            err       <= 1'b0;
            homed     <= 1'b0;
            stop_seen <= 1'b0;
            crossed   <= 1'b0;
            err_after_rev_ok <= 1'b0;
            pos_load  <= 1'b0;
            pos_load_value <= 32'h00000000;
        end
        else
        begin
            state    <= next_state;
            pos_load <= 1'b0;
            if (state == ST_IDLE && go)
            begin
                done      <= 1'b0;
                err       <= 1'b0;
                stop_seen <= 1'b0;
                crossed   <= 1'b0;
            end
            if (state == ST_IDLE && go && mode == `HSQ_MODE_ABS)
            begin
                pos_load       <= 1'b1;
                pos_load_value <= loop_feedback_position +
                                  feedback_position_offset;
                homed          <= 1'b1;
                done           <= 1'b1;
            end
            if (state == ST_SEEK && |(next_state & (ST_REV | ST_IDX)))
            begin
                err_after_rev_ok <= 1'b1;
                stop_seen        <= 1'b1;
            end
            else if (!mech_stop)
                err_after_rev_ok <= 1'b0;
            if (state == ST_REV && sw_on)
                crossed <= 1'b1;
            if (next_state == ST_SETL && state != ST_SETL)
            begin
                pos_load       <= 1'b1;
                pos_load_value <= home_pos;
                homed          <= 1'b1;
            end
            if (state == ST_SETL && ramp_zero)
                done <= 1'b1;
            if (next_state == ST_HALT && state != ST_HALT)
                err <= 1'b1;
        end
    end

    // current clamp while homing, velocity and nv save outputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vel_cmd       <= 16'sh0000;
            current_cmd   <= 16'sh0000;
            nv_save       <= 1'b0;
            nv_save_value <= 32'h00000000;
        end
        else
        begin
            vel_cmd <= ramp_vel;
            nv_save <= save_req;
            nv_save_value <= feedback_position_offset;
            if (busy && current_demand > $signed(homing_peak_current))
                current_cmd <= $signed(homing_peak_current);
            else if (busy && current_demand < -$signed(homing_peak_current))
                current_cmd <= -$signed(homing_peak_current);
            else
                current_cmd <= current_demand;
        end
    end

    // velocity ramp toward the sequencer target
    hsq_ramp u_ramp
    (
        .pclk    (pclk),
        .presetn (presetn),
        .target  (target),
        .step    (accel_step),
        .vel     (ramp_vel),
        .at_zero (ramp_zero)
    );

    // task table and trigger arbitration
    hsq_task u_task
    (
        .pclk        (pclk),
        .presetn     (presetn),
        .load        (task_load),
        .load_index  (stg_index),
        .load_target (stg_target),
        .load_next   (stg_next),
        .load_chain  (stg_chain),
        .net_start   (net_start),
        .net_index   (net_index),
        .din_start   (din_rise & tcfg[`HSQ_TCFG_DIN_EN]),
        .din_index   (tcfg[3:0]),
        .bcd_start   (bcd_rise & tcfg[`HSQ_TCFG_BCD_EN]),
        .bcd_index   (sync2[7:4]),
        .done        (task_done),
        .start       (task_start),
        .index       (task_index),
        .target      (task_target)
    );
endmodule

// >>> inc/hsq_regs.vh
// register offsets, fields and reset values of the homing sequencer
`ifndef HSQ_REGS_VH
`define HSQ_REGS_VH
// apb byte offsets
`define HSQ_CTRL_OFF     8'h00
`define HSQ_STATUS_OFF   8'h04
`define HSQ_HOMEPOS_OFF  8'h08
`define HSQ_THRESH_OFF   8'h0c
`define HSQ_IPEAK_OFF    8'h10
`define HSQ_HVEL_OFF     8'h14
`define HSQ_ACCEL_OFF    8'h18
`define HSQ_FBOFS_OFF    8'h1c
`define HSQ_TSTAGE_OFF   8'h20
`define HSQ_TTARGET_OFF  8'h24
`define HSQ_TLOAD_OFF    8'h28
`define HSQ_TCMD_OFF     8'h2c
`define HSQ_TCFG_OFF     8'h30
// control fields
`define HSQ_CTRL_START   0
`define HSQ_CTRL_DIR     1
`define HSQ_CTRL_AUTO    2
`define HSQ_CTRL_SAVE    3
`define HSQ_CTRL_MODE_LO 4
`define HSQ_CTRL_MODE_HI 7
// homing modes
`define HSQ_MODE_INDEX   4'ha
`define HSQ_MODE_SWITCH  4'hc
`define HSQ_MODE_ABS     4'hd
// task staging fields: index [3:0], next [7:4], chain enable [8]
`define HSQ_TST_NEXT_LO  4
`define HSQ_TST_NEXT_HI  7
`define HSQ_TST_CHAIN    8
// task config fields: linked input task [3:0], input en [4], bcd en [5]
`define HSQ_TCFG_DIN_EN  4
`define HSQ_TCFG_BCD_EN  5
// reset values
`define HSQ_MODE_RST     4'hc
`define HSQ_THRESH_RST   32'h00001000
`define HSQ_IPEAK_RST    16'h0400
`define HSQ_HVEL_RST     16'h0100
`define HSQ_ACCEL_RST    16'h0004
`define HSQ_ENTRIES      16
`endif

// >>> rtl/hsq_ramp.v
// velocity ramp generator for homing moves
`timescale 1ns/1ps
module hsq_ramp
(
    // clock and reset
    input  wire               pclk,
    input  wire               presetn,
    // target and slope
    input  wire signed [15:0] target,
    input  wire        [15:0] step,
    // ramp output
    output reg  signed [15:0] vel,
    output wire               at_zero
);
    wire signed [16:0] up   = {vel[15], vel} + $signed({1'b0, step});
    wire signed [16:0] down = {vel[15], vel} - $signed({1'b0, step});
    wire signed [16:0] tgt  = {target[15], target};

    assign at_zero = (vel == 16'sh0000);

    // step toward target, never overshooting it
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vel <= 16'sh0000;
        else if (vel < target)
            vel <= (up > tgt) ? target : up[15:0];
        else if (vel > target)
            vel <= (down < tgt) ? target : down[15:0];
    end
endmodule

// >>> rtl/hsq_task.v
// motion task table and start arbitration
`timescale 1ns/1ps
`include "hsq_regs.vh"
module hsq_task
(
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // table load port
    input  wire        load,
    input  wire [3:0]  load_index,
    input  wire [31:0] load_target,
    input  wire [3:0]  load_next,
    input  wire        load_chain,
    // triggers
    input  wire        net_start,
    input  wire [3:0]  net_index,
    input  wire        din_start,
    input  wire [3:0]  din_index,
    input  wire        bcd_start,
    input  wire [3:0]  bcd_index,
    input  wire        done,
    // started task
    output reg         start,
    output reg  [3:0]  index,
    output reg  [31:0] target
);
    reg [31:0] tab_target [0:`HSQ_ENTRIES-1];
    reg [3:0]  tab_next   [0:`HSQ_ENTRIES-1];
    reg [`HSQ_ENTRIES-1:0] tab_chain;
    reg        sel_go;
    reg [3:0]  sel_idx;
    integer    i;

    // only committed entries live here; staging stays outside
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tab_chain <= {`HSQ_ENTRIES{1'b0}};
            for (i = 0; i < `HSQ_ENTRIES; i = i + 1)
            begin
                tab_target[i] <= 32'h00000000;
                tab_next[i]   <= 4'h0;
            end
        end
        else if (load)
        begin
            tab_target[load_index] <= load_target;
            tab_next[load_index]   <= load_next;
            tab_chain[load_index]  <= load_chain;
        end
    end

    // trigger priority: network, input, bcd, then chaining
    always @*
    begin
        sel_go  = 1'b1;
        sel_idx = net_index;
        if (net_start)
            sel_idx = net_index;
        else if (din_start)
            sel_idx = din_index;
        else if (bcd_start)
            sel_idx = bcd_index;
        else if (done && tab_chain[index])
            sel_idx = tab_next[index];
        else
            sel_go = 1'b0;
    end

    // start pulse with the selected entry
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start  <= 1'b0;
            index  <= 4'h0;
            target <= 32'h00000000;
        end
        else
        begin
            start <= sel_go;
            if (sel_go)
            begin
                index  <= sel_idx;
                target <= tab_target[sel_idx];
            end
        end
    end
endmodule

// >>> dv/hsq_checker.sv
// assertions on the homing sequencer ports
`timescale 1ns/1ps
module hsq_checker
(
    // clock and reset
    input wire               pclk,
    input wire               presetn,
    // apb side
    input wire               psel,
    input wire               penable,
    input wire               pwrite,
    input wire        [7:0]  paddr,
    input wire        [31:0] pwdata,
    input wire               pready,
    input wire               pslverr,
    // motion side
    input wire signed [31:0] following_error,
    input wire signed [15:0] vel_cmd,
    input wire signed [15:0] current_cmd,
    input wire               pos_load
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // velocity settles after a load
    sequence s_ramp_down;
        ##[1:300] vel_cmd == 16'sh0000;
    endsequence
    // mode 13 start written over the bus
    sequence s_abs_start;
        psel && penable && pready && pwrite && paddr == 8'h00
            && pwdata[7:4] == 4'hd && pwdata[0];
    endsequence
    a_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_map: assert property (pready |-> pslverr ==
        (paddr > 8'h30 || paddr[1:0] != 2'b00))
        else $error("pslverr off the map");
    a_peak_clamp: assert property (
        vel_cmd != 0 && $past(vel_cmd) != 0 |->
        current_cmd <= 16'sh0400 && current_cmd >= -16'sh0400)
        else $error("current command above peak");
    a_load_pulse: assert property (pos_load |=> !pos_load)
        else $error("load pulse too long");
    a_load_ramp: assert property (pos_load |-> s_ramp_down)
        else $error("no ramp to zero after load");
    a_stop_reverse: assert property (
        following_error < -32'sd4096 && vel_cmd < 0 |->
        ##[1:300] vel_cmd > 0)
        else $error("no reversal after stop");
    a_abs_load: assert property (s_abs_start |-> ##[1:3] pos_load)
        else $error("absolute mode did not load");
endmodule
bind hsq_top hsq_checker u_chk (.*);

// >>> dv/hsq_motor.sv
// motor, feedback and home switch model
`timescale 1ns/1ps
module hsq_motor
(
    // clock and reset
    input  wire               pclk,
    input  wire               presetn,
    // drive side
    input  wire signed [15:0] vel_cmd,
    // machine side
    output wire               home_switch,
    output wire signed [31:0] following_error,
    output wire        [31:0] loop_feedback_position,
    output wire signed [15:0] current_demand
);
    localparam signed [31:0] STOP = -32'sd30000;
    reg  signed [31:0] pos;
    wire signed [31:0] next_pos = pos + vel_cmd;
    // travel integrates velocity, the hard stop blocks it
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pos <= 32'sd0;
        else
            pos <= (next_pos < STOP) ? STOP : next_pos;
    end
    // switch active over a window, lag builds against the stop
    assign home_switch = pos > 32'sd20000 && pos < 32'sd60000;
    assign following_error = (pos == STOP && vel_cmd < 0) ? -32'sd8192 : 0;
    assign loop_feedback_position = pos; // multi-turn, never wraps
    assign current_demand = vel_cmd <<< 5;
endmodule

// >>> dv/test_homing_sequencer_switch_absolute.sv
// self-checking bench for the homing sequencer
`timescale 1ns/1ps
module test_homing_sequencer_switch_absolute;
    logic               pclk, presetn, psel, penable, pwrite, re;
    logic               drive_enable, task_input;
    logic        [7:0]  paddr;
    logic        [31:0] pwdata, rd, lv, sv, tt;
    logic        [3:0]  ti;
    logic        [40:0] rows [8];
    wire         [31:0] prdata, pos_load_value, nv_save_value, task_target;
    wire         [31:0] loop_feedback_position;
    wire                pready, pslverr, pos_load, nv_save, task_start;
    wire                home_switch;
    wire         [3:0]  task_index;
    wire signed  [31:0] following_error;
    wire signed  [15:0] vel_cmd, current_cmd, current_demand;
    int                 err_count, samples_checked, k;
    hsq_motor u_motor (.pclk, .presetn, .vel_cmd, .home_switch,
        .following_error, .loop_feedback_position, .current_demand);
    hsq_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .home_switch, .index_pulse(home_switch),
        .task_input, .bcd_inputs(4'h0), .bcd_strobe(1'b0), .drive_enable,
        .following_error, .loop_feedback_position, .current_demand,
        .task_done(1'b0), .nv_offset(32'h40), .vel_cmd, .current_cmd,
        .pos_load, .pos_load_value, .nv_save, .nv_save_value, .task_start,
        .task_index, .task_target);
    // clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // capture load, save and task start pulses
    always @(posedge pclk)
    begin
        if (pos_load)
            lv <= pos_load_value;
        if (nv_save)
            sv <= nv_save_value;
        if (task_start)
            {ti, tt} <= {task_index, task_target};
    end
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        {rd, re} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task chk(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // start homing, poll status until done or error
    task home(input logic [31:0] ctrl);
        apb(1'b1, 8'h00, ctrl);
        do
            apb(1'b0, 8'h04, 32'h0);
        while (rd[1:0] === 2'b00);
    endtask
    task end_sim;
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #900000;
        err_count++;
        end_sim;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {drive_enable, task_input, lv, sv, ti, tt} = '0;
        rows = '{{8'h00, 32'hc2, 1'b0}, {8'h04, 32'h10, 1'b0},
            {8'h0c, 32'h1000, 1'b0}, {8'h10, 32'h400, 1'b0},
            {8'h14, 32'h100, 1'b0}, {8'h18, 32'h4, 1'b0},
            {8'h1c, 32'h40, 1'b0}, {8'h40, 32'h0, 1'b1}};
        repeat (6) @(posedge pclk);
        {presetn, drive_enable} <= 2'b11;
        // reset values and unmapped access
        for (k = 0; k < 8; k++)
        begin
            apb(1'b0, rows[k][40:33], 32'h0);
            chk({rd, re}, rows[k][32:0]);
        end
        // negative seek hits the stop, reverses round the switch
        apb(1'b1, 8'h08, 32'habc);
        home(32'hc1);
        chk({rd[3], rd[1:0]}, 32'h5);
        chk(lv, 32'habc);
        // switch active at start: reset move then positive seek
        apb(1'b1, 8'h08, 32'hdef);
        home(32'hc3);
        chk({rd[3], rd[1:0]}, 32'h1);
        chk(lv, 32'hdef);
        // index mode: stop, reverse, load on the index edge
        lv = '0;
        home(32'ha1);
        chk({rd[3], rd[1:0]}, 32'h5);
        chk(lv, 32'hdef);
        // absolute mode takes feedback plus offset, then saves it
        apb(1'b1, 8'h1c, 32'h100);
        home(32'hd1);
        chk({rd[2], rd[1:0]}, 32'h5);
        chk(lv, loop_feedback_position + 32'h100);
        apb(1'b1, 8'h00, 32'hd8);
        repeat (3) @(posedge pclk);
        chk(sv, 32'h100);
        // network start of a loaded task, then unloaded edit
        apb(1'b1, 8'h20, 32'h3);
        apb(1'b1, 8'h24, 32'h1234);
        apb(1'b1, 8'h28, 32'h1);
        apb(1'b1, 8'h2c, 32'h3);
        repeat (3) @(posedge pclk);
        chk({ti, tt}, {4'h3, 32'h1234});
        apb(1'b1, 8'h24, 32'h5555);
        apb(1'b1, 8'h30, 32'h13);
        tt = '0;
        task_input <= 1'b1;
        repeat (4) @(posedge pclk);
        task_input <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(tt, 32'h1234);
        end_sim;
    end
endmodule
